// ---- rtl/rsqs_pkg.sv ----
// shared constants and types for the reset strap and quick start control
package rsqs_pkg;
    localparam int RSQS_CFG_W = 32;
    localparam int RSQS_QS_BIT = 5;
    localparam logic [31:0] RSQS_CFG_RST = 32'h0000_0000;
    localparam int RSQS_STRAP_W = 32;
    localparam logic [31:0] RSQS_STRAP_RST = 32'h0000_0000;

    typedef enum logic [1:0]
    {
        RSQS_RUN,
        RSQS_STOP_GRANT,
        RSQS_QUICK_START
    } rsqs_state_type;

    typedef struct packed
    {
        logic bpri_snoop;
        logic sym_snoop;
        logic intr;
    } rsqs_req_type;
endpackage : rsqs_pkg

// ---- rtl/rsqs_strap_latch.sv ----
// strap capture register loaded once at reset release
`timescale 1ns/1ns
module rsqs_strap_latch
    import rsqs_pkg::*;
#(
    parameter int W = RSQS_STRAP_W
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] strap_i,
    output logic [W-1:0] strap_o
);
    logic rst_d_r;

    always_ff @(posedge clk_i)
    begin
        rst_d_r <= rst_i;
    end

    // load only on the first edge after release, then frozen, through the next reset too, until the next release
    always_ff @(posedge clk_i)
    begin
        if (rst_d_r && !rst_i)
        begin
            strap_o <= strap_i; // [R1]
        end
        else if (rst_i)
        begin
            strap_o <= strap_o;
        end
    end
endmodule : rsqs_strap_latch

// ---- rtl/rsqs_top.sv ----
// reset strap capture and stop clock low power state control
// Behaviour
// [R1] straps captured once per reset, at the edge where reset is released
// [R2] stop clock request without quick start selection enters stop grant
// [R3] strap held active at release makes stop clock enter quick start instead
// [R4] quick start still services priority agent snoops like stop grant
// [R5] quick start ignores snoops from symmetric bus masters
// [R6] quick start does not latch incoming interrupt requests
// [R7] latched quick start selection reads as bit five of configuration word
// [R8] quick start selection held constant until the next reset
`timescale 1ns/1ns
module rsqs_top
    import rsqs_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic STOP_CLOCK_REQUEST_N_I,
    input wire logic QUICK_START_STRAP_N_I,
    input wire logic BPRI_SNOOP_I,
    input wire logic SYM_SNOOP_I,
    input wire logic INTR_I,
    output logic [RSQS_CFG_W-1:0] CFG_WORD_O,
    output logic STOP_GRANT_O,
    output logic QUICK_START_O,
    output logic BPRI_SNOOP_ACK_O,
    output logic SYM_SNOOP_ACK_O,
    output logic INTR_PENDING_O
);
    logic [RSQS_STRAP_W-1:0] strap_vec;
    logic [RSQS_STRAP_W-1:0] strap_q;
    rsqs_state_type state_r;
    rsqs_state_type state_nxt;
    rsqs_req_type req;
    logic qs_en;
    logic intr_pend_r;
    logic bpri_ack_r;
    logic sym_ack_r;
    logic rst_d_r;

    // low power test shared by the exit and stay checks
    function automatic logic is_low_power(input rsqs_state_type st);
        return (st == RSQS_STOP_GRANT) || (st == RSQS_QUICK_START);
    endfunction : is_low_power

    always_comb
    begin
        strap_vec = RSQS_STRAP_RST;
        // strap pin is active low, stored as one for quick start
        strap_vec[RSQS_QS_BIT] = !QUICK_START_STRAP_N_I; // [R3]
    end

    rsqs_strap_latch #(
        .W(RSQS_STRAP_W)
    ) u_latch (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .strap_i(strap_vec),
        .strap_o(strap_q)
    );

    // strap latch value is only trusted after release; during reset report zero
    always_ff @(posedge CORE_CLK_I)
    begin
        rst_d_r <= SYS_RST_I;
    end

    assign qs_en = strap_q[RSQS_QS_BIT] && !SYS_RST_I && !rst_d_r; // [R8]

    always_comb
    begin
        CFG_WORD_O = RSQS_CFG_RST;
        CFG_WORD_O[RSQS_QS_BIT] = qs_en; // [R7]
    end

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            RSQS_RUN:
            begin
                if (!STOP_CLOCK_REQUEST_N_I)
                begin
                    state_nxt = qs_en ? RSQS_QUICK_START : RSQS_STOP_GRANT; // [R2] [R3]
                end
            end
            RSQS_STOP_GRANT, RSQS_QUICK_START:
            begin
                if (STOP_CLOCK_REQUEST_N_I)
                begin
                    state_nxt = RSQS_RUN;
                end
            end
            default:
            begin
                state_nxt = RSQS_RUN;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            state_r <= RSQS_RUN;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign req = '{bpri_snoop: BPRI_SNOOP_I, sym_snoop: SYM_SNOOP_I, intr: INTR_I};

    // snoop answers registered one cycle after the request
    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            bpri_ack_r <= 1'b0;
            sym_ack_r <= 1'b0;
        end
        else
        begin
            bpri_ack_r <= req.bpri_snoop; // [R4]
            sym_ack_r <= req.sym_snoop && (state_r != RSQS_QUICK_START); // [R5]
        end
    end

    // pending interrupt is sticky until stop clock released in run; dropped in quick start
    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            intr_pend_r <= 1'b0;
        end
        else if (state_r == RSQS_QUICK_START)
        begin
            intr_pend_r <= 1'b0; // [R6]
        end
        else if (req.intr)
        begin
            intr_pend_r <= 1'b1;
        end
        else if (state_r == RSQS_RUN)
        begin
            intr_pend_r <= 1'b0;
        end
    end

    assign STOP_GRANT_O = (state_r == RSQS_STOP_GRANT);
    assign QUICK_START_O = (state_r == RSQS_QUICK_START);
    assign BPRI_SNOOP_ACK_O = bpri_ack_r;
    assign SYM_SNOOP_ACK_O = sym_ack_r;
    assign INTR_PENDING_O = intr_pend_r;

    // state entry, stay and exit
    sg_entry_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R2]
        (state_r == RSQS_RUN && !STOP_CLOCK_REQUEST_N_I && !qs_en) |=> STOP_GRANT_O)
        else $error("stop grant not entered");
    qs_entry_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R3]
        (state_r == RSQS_RUN && !STOP_CLOCK_REQUEST_N_I && qs_en) |=> QUICK_START_O)
        else $error("quick start not entered");
    sg_stay_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R2]
        STOP_GRANT_O && !STOP_CLOCK_REQUEST_N_I |=> STOP_GRANT_O)
        else $error("stop grant left while requested");
    qs_stay_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R3]
        QUICK_START_O && !STOP_CLOCK_REQUEST_N_I |=> QUICK_START_O)
        else $error("quick start left while requested");
    lp_exit_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R2] [R3]
        is_low_power(state_r) && STOP_CLOCK_REQUEST_N_I |=> state_r == RSQS_RUN)
        else $error("low power not left on release");
    run_stay_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R2]
        state_r == RSQS_RUN && STOP_CLOCK_REQUEST_N_I |=> !is_low_power(state_r))
        else $error("low power entered without request");

    // snoops and interrupts in each state
    bpri_snoop_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R4]
        BPRI_SNOOP_I |=> BPRI_SNOOP_ACK_O)
        else $error("priority snoop not serviced");
    sym_snoop_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R5]
        QUICK_START_O |=> !SYM_SNOOP_ACK_O)
        else $error("symmetric snoop answered in quick start");
    sym_run_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R5]
        SYM_SNOOP_I && !QUICK_START_O |=> SYM_SNOOP_ACK_O)
        else $error("symmetric snoop not answered outside quick start");
    intr_drop_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R6]
        QUICK_START_O |=> !INTR_PENDING_O)
        else $error("interrupt latched in quick start");
    intr_latch_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R6]
        INTR_I && !QUICK_START_O |=> INTR_PENDING_O)
        else $error("interrupt not latched outside quick start");
    pend_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R6]
        STOP_GRANT_O && INTR_PENDING_O |=> INTR_PENDING_O)
        else $error("pending interrupt lost in stop grant");

    // strap capture and configuration word; the latch is checked too, not only its decode
    cfg_bit_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R7]
        CFG_WORD_O[RSQS_QS_BIT] == qs_en && (CFG_WORD_O & ~(32'h1 << RSQS_QS_BIT)) == 32'h0)
        else $error("configuration word wrong");
    cfg_rst_a: assert property (@(posedge CORE_CLK_I) // [R7]
        SYS_RST_I |-> CFG_WORD_O == RSQS_CFG_RST)
        else $error("configuration word not clear in reset");
    cfg_cap_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R1] [R7]
        (rst_d_r && !SYS_RST_I && !QUICK_START_STRAP_N_I) |=> CFG_WORD_O[RSQS_QS_BIT])
        else $error("active strap not reported after release");
    qs_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R8]
        !rst_d_r |=> $stable(qs_en))
        else $error("quick start selection changed");
    strap_freeze_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [R1] [R8]
        !rst_d_r |=> $stable(strap_q))
        else $error("strap latch changed after capture");
    strap_cap_a: assert property (@(posedge CORE_CLK_I) // [R1]
        (rst_d_r && !SYS_RST_I) |=> strap_q[RSQS_QS_BIT] == !$past(QUICK_START_STRAP_N_I))
        else $error("strap not captured at release");

    // covers for the main scenarios
    qs_seen_c: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) QUICK_START_O);
    sg_seen_c: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) STOP_GRANT_O);
    qs_snoop_c: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) QUICK_START_O && BPRI_SNOOP_I);
    qs_intr_c: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) QUICK_START_O && INTR_I);
    sg_exit_c: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) STOP_GRANT_O && STOP_CLOCK_REQUEST_N_I);
endmodule : rsqs_top

// ---- bench/rsqs_chipset_model.sv ----
// chipset model driving reset, quick start strap and stop clock request
`timescale 1ns/1ns
module rsqs_chipset_model
(
    input wire logic clk_i,
    output logic rst_o,
    output logic strap_n_o,
    output logic stop_n_o
);
    initial
    begin
        rst_o = 1'b1;
        strap_n_o = 1'b1;
        stop_n_o = 1'b1;
    end

    // called at a falling edge; reset is held for 5 cycles
    task automatic reset_cycle(input logic qs);
        rst_o = 1'b1;
        strap_n_o = qs; // wrong level in reset, only the release value may count
        repeat (5) @(negedge clk_i);
        rst_o = 1'b0;
        strap_n_o = ~qs; // strap held at the selected level across release, active only when qs is one
        @(negedge clk_i);
        strap_n_o = qs; // strap flips after capture, must be ignored
        repeat (2) @(negedge clk_i);
    endtask : reset_cycle

    task automatic stop_req(input logic on);
        stop_n_o = ~on;
        @(negedge clk_i);
    endtask : stop_req
endmodule : rsqs_chipset_model

// ---- bench/rsqs_top_tb.sv ----
// self-checking bench for reset strap and quick start control
`timescale 1ns/1ns
module rsqs_top_tb;
    import rsqs_pkg::*;
    logic core_clk, sys_rst, stop_n, strap_n, bpri, sym, intr;
    logic [RSQS_CFG_W-1:0] cfg_word;
    logic stop_grant, quick_start, bpri_ack, sym_ack, intr_pend;
    int error_cnt = 0;
    int checks_done = 0;

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    rsqs_chipset_model u_cs (.clk_i(core_clk), .rst_o(sys_rst), .strap_n_o(strap_n), .stop_n_o(stop_n));

    rsqs_top uut (.CORE_CLK_I(core_clk), .SYS_RST_I(sys_rst), .STOP_CLOCK_REQUEST_N_I(stop_n),
        .QUICK_START_STRAP_N_I(strap_n), .BPRI_SNOOP_I(bpri), .SYM_SNOOP_I(sym), .INTR_I(intr),
        .CFG_WORD_O(cfg_word), .STOP_GRANT_O(stop_grant), .QUICK_START_O(quick_start),
        .BPRI_SNOOP_ACK_O(bpri_ack), .SYM_SNOOP_ACK_O(sym_ack), .INTR_PENDING_O(intr_pend));

    // status flags packed: stop grant, quick start, priority ack, symmetric ack, pending
    function automatic logic [31:0] st();
        return {27'h0, stop_grant, quick_start, bpri_ack, sym_ack, intr_pend};
    endfunction : st

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input logic [2:0] req);
        {bpri, sym, intr} = req;
        @(negedge core_clk);
    endtask : cyc

    // run is back one edge after release; pending clears only one edge later, in run
    task automatic leave_low_power();
        u_cs.stop_req(1'b0);
        cyc(3'h0);
        cyc(3'h0);
        chk(st(), 32'h00);
    endtask : leave_low_power

    task automatic test_quick_start();
        u_cs.reset_cycle(1'b1);
        chk(cfg_word, 32'h20);
        u_cs.stop_req(1'b1);
        chk(st(), 32'h08);
        cyc(3'h7);
        chk(st(), 32'h0C);
        cyc(3'h0);
        leave_low_power();
        chk(cfg_word, 32'h20);
        $display("quick start test done");
    endtask : test_quick_start

    task automatic test_stop_grant();
        u_cs.reset_cycle(1'b0);
        chk(cfg_word, 32'h00);
        u_cs.stop_req(1'b1);
        chk(st(), 32'h10);
        cyc(3'h7);
        chk(st(), 32'h17);
        cyc(3'h0);
        chk(st(), 32'h11);
        leave_low_power();
        chk(cfg_word, 32'h00);
        $display("stop grant test done");
    endtask : test_stop_grant

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    initial
    begin
        {bpri, sym, intr} = 3'h0;
        @(negedge core_clk);
        test_quick_start();
        test_stop_grant();
        conclude();
    end
endmodule : rsqs_top_tb
